// ==== logic/rrg_pkg.sv ====
// Purpose: Constants and types for the reset routine guard
// Assumes: One 200 MHz clock, registers on a plain strobe port
// Notes: Rules of the host and the guard follow
package rrg_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_PWR = 4'h0;
    localparam logic [3:0] OFF_RST = 4'h4;
    localparam logic [3:0] OFF_STAT = 4'h8;
    localparam logic [3:0] OFF_CNT = 4'hC;
    localparam int BIT_STBY = 0;
    localparam int BIT_PDN = 1;
    localparam int BIT_RST_REG = 0;
    localparam int BIT_RST_MOD = 1;
    localparam logic [1:0] PWR_RESET = 2'h0;
    localparam int PULSE_CYC = 4;
    localparam logic [2:0] PULSE_LAST = 3'(PULSE_CYC - 1);

    typedef struct packed {
        logic pdn;
        logic stby;
    } rrg_pwr_t;

    typedef struct packed {
        logic mod;
        logic regs;
    } rrg_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PULSE = 3'b010,
        ST_LOCK = 3'b100
    } rrg_state_t;

    // Forbidden: module-only reset while power-down is set
    function automatic logic rrg_illegal(input rrg_pwr_t p, input rrg_req_t r);
        return r.mod && !r.regs && p.pdn;
    endfunction
endpackage

// ==== logic/rrg_pulse.sv ====
// Purpose: Stretch a one-cycle request into a fixed-length pulse
// Assumes: Same clock as the caller
// Notes: Restart while busy extends the pulse
`timescale 1ns/1ps
module rrg_pulse import rrg_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Trigger and stretched output
    input wire logic i_fire,
    output logic o_busy
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic busy_r;
    logic busy_nxt;

    // Count down from the last pulse cycle
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        if (i_fire) begin
            cnt_nxt = PULSE_LAST;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            if (cnt_r == 3'h0) begin
                busy_nxt = 1'b0;
            end else begin
                cnt_nxt = cnt_r - 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_r <= 3'h0;
            busy_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign o_busy = busy_r;
endmodule

// ==== logic/rrg_top.sv ====
// Purpose: Soft-reset guard for the amplifier control side
// Assumes: Host writes power state, then reset bits, via strobe port
// Notes: Lock-up is left only by the device reset input
`timescale 1ns/1ps
module rrg_top import rrg_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Power state and reset pulses to the datapath
    output logic o_standby,
    output logic o_powerdown,
    output logic o_reg_clear,
    output logic o_mod_reset,
    output logic o_locked
);
    rrg_pwr_t pwr_r, pwr_nxt;
    rrg_state_t st_r, st_nxt;
    rrg_req_t last_r, last_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic regclr_r, regclr_nxt;
    logic fire_mod;
    logic mod_busy;
    logic mod_r;
    rrg_req_t wreq;

    assign wreq = rrg_req_t'({i_wdata[BIT_RST_MOD], i_wdata[BIT_RST_REG]});

    // Stretched module reset; interpolation filter and DAC restart
    rrg_pulse u_mod (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_fire(fire_mod),
        .o_busy(mod_busy)
    );

    // Request evaluation uses the power state already held
    always_comb begin
        st_nxt = st_r;
        pwr_nxt = pwr_r;
        last_nxt = last_r;
        cnt_nxt = cnt_r;
        regclr_nxt = 1'b0;
        fire_mod = 1'b0;
        unique case (st_r)
            ST_IDLE, ST_PULSE: begin
                if (i_wr && i_addr == OFF_PWR) begin
                    pwr_nxt.stby = i_wdata[BIT_STBY];
                    pwr_nxt.pdn = i_wdata[BIT_PDN];
                end else if (i_wr && i_addr == OFF_RST && (wreq.mod || wreq.regs)) begin
                    last_nxt = wreq;
                    cnt_nxt = cnt_r + 8'h01;
                    if (rrg_illegal(pwr_r, wreq)) begin
                        st_nxt = ST_LOCK;
                    end else begin
                        // Legal request: register clear in any power state, module-only reset without power-down
                        regclr_nxt = wreq.regs;
                        fire_mod = wreq.mod;
                        st_nxt = ST_PULSE;
                    end
                end else if (st_r == ST_PULSE && !mod_busy) begin
                    st_nxt = ST_IDLE;
                end
                // Register clear returns power state to reset value
                if (regclr_nxt) begin
                    pwr_nxt = rrg_pwr_t'(PWR_RESET);
                end
            end
            ST_LOCK: begin
                // Unresponsive: every access ignored, reads return zero
                st_nxt = ST_LOCK;
            end
            default: begin
                st_nxt = ST_LOCK;
            end
        endcase
    end

    // Read mux; locked device answers nothing but zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_rd && st_r != ST_LOCK) begin
            unique case (i_addr)
                OFF_PWR: rdata_nxt = {6'h00, pwr_r.pdn, pwr_r.stby};
                OFF_RST: rdata_nxt = {6'h00, last_r.mod, last_r.regs};
                OFF_STAT: rdata_nxt = {5'h00, 1'b0, mod_busy, st_r == ST_PULSE};
                OFF_CNT: rdata_nxt = cnt_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= ST_IDLE;
            pwr_r <= rrg_pwr_t'(PWR_RESET);
            last_r <= '0;
            cnt_r <= 8'h00;
            regclr_r <= 1'b0;
            rdata_r <= 8'h00;
            mod_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pwr_r <= pwr_nxt;
            last_r <= last_nxt;
            cnt_r <= cnt_nxt;
            regclr_r <= regclr_nxt;
            rdata_r <= rdata_nxt;
            mod_r <= mod_busy;
        end
    end

    assign o_rdata = rdata_r;
    assign o_standby = pwr_r.stby;
    assign o_powerdown = pwr_r.pdn;
    assign o_reg_clear = regclr_r;
    assign o_mod_reset = mod_r;
    // Lock pin is the one-hot lock bit itself, so it leaves straight from a flop
    assign o_locked = st_r[2];
endmodule

// ==== sim/rrg_host.sv ====
// Purpose: Host model on the register port
// Assumes: Strobe port only
// Notes: Forbidden combos only as told
`timescale 1ns/1ps
module rrg_host import rrg_pkg::*; (
    // Clock and read data
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    // Requests
    output logic [ADDR_W-1:0] o_addr = '0,
    output logic [7:0] o_wdata = '0,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0
);
    // Write; bus shows inverse once released
    task automatic put(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    // Read; data taken in the next cycle
    task automatic get(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask
endmodule

// ==== sim/rrg_chk_assertions.sv ====
// Purpose: Port checks for the guard
// Assumes: One clock domain
// Notes: Bound below
`timescale 1ns/1ps
module rrg_chk import rrg_pkg::*; (
    // Watched ports
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic o_powerdown,
    input wire logic o_reg_clear,
    input wire logic o_mod_reset,
    input wire logic o_locked
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Reset write while still responsive
    wire logic rw = i_wr && i_addr == OFF_RST && !o_locked;
    clear_cause_a: assert property (o_reg_clear |-> $past(rw) && $past(i_wdata[0]))
        else $error("clear without request");
    lock_entry_a: assert property (rw && i_wdata[1:0] == 2'h2 && o_powerdown |=> o_locked)
        else $error("forbidden request not locked");
    lock_hold_a: assert property (o_locked |=> o_locked && !o_reg_clear)
        else $error("lock left or write taken");
    reg_reset_a: assert property (rw && i_wdata[0] |=> o_reg_clear && !o_locked)
        else $error("register clear missing");
    mod_pulse_a: assert property (
        rw && i_wdata[1] && (i_wdata[0] || !o_powerdown) |-> ##2 o_mod_reset [*4])
        else $error("module pulse wrong");
endmodule
bind rrg_top rrg_chk chk_u (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .o_powerdown,
    .o_reg_clear, .o_mod_reset, .o_locked);

// ==== sim/reset_routine_guard_bench.sv ====
// Purpose: Self-checking bench for the guard
// Assumes: Host model drives the port
// Notes: Each trial resets first
`timescale 1ns/1ps
module reset_routine_guard_bench;
    import rrg_pkg::*;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [ADDR_W-1:0] a;
    logic [7:0] wd, rdat, rv;
    logic wr, rd, sb, pd, rc, mr, lk;
    int num_errors = 0;
    int check_count = 0;
    int seed = 32'h08b989d4;
    rrg_host host_u (.i_clk, .i_rdata(rdat), .o_addr(a), .o_wdata(wd), .o_wr(wr), .o_rd(rd));
    rrg_top dut_u (.i_clk, .i_resetn, .i_addr(a), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdat), .o_standby(sb), .o_powerdown(pd), .o_reg_clear(rc),
        .o_mod_reset(mr), .o_locked(lk));
    // 200 MHz clock
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic chk(input logic ok);
        check_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED %0t output mismatch", $time);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Expected lock-up: module-only request while power-down is held
    function automatic logic lock_expected(input logic [1:0] p, input logic [1:0] q);
        return q[BIT_RST_MOD] && !q[BIT_RST_REG] && p[BIT_PDN];
    endfunction
    // Power state first, then the reset request
    task automatic trial(input logic [1:0] p, input logic [1:0] q);
        logic e;
        e = lock_expected(p, q);
        @(posedge i_clk) i_resetn <= 1'b0;
        @(posedge i_clk) i_resetn <= 1'b1;
        host_u.put(OFF_PWR, {6'h0, p});
        host_u.get(OFF_PWR, rv);
        chk(rv === {6'h0, p} && {pd, sb} === p);
        host_u.put(OFF_RST, {6'h0, q});
        #1 chk(lk === e && rc === (q[0] && !e));
        @(posedge i_clk) #1 chk(mr === (q[1] && !e));
        // Module pulse still running three cycles after the request
        host_u.get(OFF_STAT, rv);
        chk(rv === ((q[1] && !e) ? 8'h03 : 8'h00));
        host_u.get(OFF_PWR, rv);
        chk(rv === ((e || q[0]) ? 8'h00 : {6'h0, p}));
        // Empty request must not count; locked device answers zero
        host_u.put(OFF_RST, 8'h00);
        host_u.get(OFF_CNT, rv);
        chk(rv === (e ? 8'h00 : 8'h01));
        host_u.get(OFF_RST, rv);
        chk(rv === (e ? 8'h00 : {6'h0, q}));
    endtask
    // Full table first, random mixes after
    initial begin
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            if (i < 12) trial(2'(i / 3), 2'(i % 3 + 1));
            else trial(2'($random(seed)), 2'($unsigned($random(seed)) % 3 + 1));
        end
        tally_and_finish();
    end
    // Hang guard, several times the roughly 4 us that 40 trials take
    initial begin
        #20000;
        num_errors++;
        tally_and_finish();
    end
endmodule
